// ==== mcepwm_pkg.sv ====
// Constants shared by the multi-channel edge PWM block: register map, field layout, reset values.
// Assumes a 32-bit APB register bus; every register takes one aligned word.
package mcepwm_pkg;

    // ------------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------------
    localparam int NUM_MATCH  = 7;
    localparam int NUM_OUT    = 6;
    localparam int ADDR_W     = 8;

    // ------------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_STATUS   = 8'h00;
    localparam logic [7:0] ADDR_CTRL     = 8'h04;
    localparam logic [7:0] ADDR_COUNT    = 8'h08;
    localparam logic [7:0] ADDR_PRESCALE = 8'h0c;
    localparam logic [7:0] ADDR_PRECOUNT = 8'h10;
    localparam logic [7:0] ADDR_MATCHCTL = 8'h14;
    localparam logic [7:0] ADDR_PWMCTL   = 8'h18;
    localparam logic [7:0] ADDR_RELEASE  = 8'h1c;
    localparam logic [7:0] ADDR_INTMASK  = 8'h20;
    localparam logic [7:0] ADDR_MATCH0   = 8'h40;

    // ------------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------------
    localparam int CTRL_RUN   = 0;
    localparam int CTRL_CLEAR = 1;
    localparam int CTRL_PWMEN = 3;

    // Match control: three bits per match register
    localparam int MC_INT   = 0;
    localparam int MC_RESET = 1;
    localparam int MC_STOP  = 2;

    // PWM control: bits 2..6 select double edge for outputs 2..6, bits 9..14 enable outputs 1..6
    localparam int PC_DBL_LSB = 2;
    localparam int PC_EN_LSB  = 9;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [31:0] RST_WORD = 32'h0000_0000;

endpackage

// ==== mcepwm_output.sv ====
// One PWM output channel: edge selection for single or double edge control.
// Assumes match pulses from the shared counter arrive as one-cycle strobes.
`timescale 1ns/1ps
module mcepwm_output (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic rst,
    // Control
    input  wire logic enable,
    input  wire logic doubleEdge,
    // Match strobes
    input  wire logic cycleHit,
    input  wire logic setHit,
    input  wire logic ownHit,
    // Output
    output logic      pwmOut
);
    logic outFf;
    logic nxtOut;
    logic setEv;
    logic clrEv;

    // Single edge: rises at cycle start, falls at own match.
    // Double edge: rises at previous match, falls at own match; order decides polarity.
    assign setEv = doubleEdge ? setHit : cycleHit;
    assign clrEv = ownHit;
    // Clear wins so a zero-width setting gives a constant low output
    assign nxtOut = clrEv ? 1'b0 : (setEv ? 1'b1 : outFf);

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            outFf <= 1'b0;
        end else begin
            outFf <= nxtOut;
        end
    end

    assign pwmOut = enable & outFf;
endmodule

// ==== mcepwm_top.sv ====
// Multi-channel edge PWM with a prescaled 32-bit timer and seven match registers.
// Assumes an APB master on clk_sys; outputs drive external loads directly.
//
// How it works
// - Count bus clocks and compare against seven match registers for actions and outputs.
// - Cycle match register zero resets the counter, setting the shared period.
// - A single-edge output falls at its own dedicated match register count.
// - Single-edge outputs go high at every cycle match unless constantly low.
// - Double-edge outputs rise at one match register and fall at another.
// - Rise before fall gives a positive pulse, fall first a negative pulse.
// - Six single-edge, five double-edge (outputs 2..6), or any mixture of outputs.
// - Each match may run on, stop, or reset the counter, optionally interrupting.
// - Period and width are any whole counts; all outputs share one rate.
// - In PWM mode new match values wait for software release, then apply glitch-free; with PWM mode off they apply at once.
// - With PWM mode off the block is an ordinary timer with matches.
// - 32-bit counter advances only after a programmable 32-bit prescaler.
//
// Chosen here: the APB slave port and the register offsets.
`timescale 1ns/1ps
module mcepwm_top (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // PWM outputs 1..6
    output logic [5:0]       pwmOut,
    // Interrupt
    output logic             irq
);
    localparam int NM = mcepwm_pkg::NUM_MATCH;

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    logic        wrStb;
    logic        rdStb;
    logic        inMatch;
    logic [2:0]  matchIdx;
    assign wrStb    = psel & penable & pwrite;
    assign rdStb    = psel & penable & ~pwrite;
    assign inMatch  = (paddr >= mcepwm_pkg::ADDR_MATCH0) && (paddr < mcepwm_pkg::ADDR_MATCH0 + 8'(4 * NM)) &&
                      (paddr[1:0] == 2'b00);
    assign matchIdx = 3'((paddr - mcepwm_pkg::ADDR_MATCH0) >> 2);

    function automatic logic hitAddr(input logic [7:0] a, input logic [7:0] r);
        hitAddr = (a == r);
    endfunction

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [31:0] ctrlFf;
    logic [31:0] prescaleFf;
    logic [31:0] preCountFf;
    logic [31:0] countFf;
    logic [20:0] matchCtlFf;
    logic [14:0] pwmCtlFf;
    logic [6:0]  releaseFf;
    logic [6:0]  statusFf;
    logic [6:0]  intMaskFf;
    logic [31:0] shadowFf [NM];
    logic [31:0] activeFf [NM];

    logic [31:0] nxtCount;
    logic [31:0] nxtPreCount;
    logic [6:0]  nxtStatus;
    logic [6:0]  nxtRelease;
    logic [31:0] nxtCtrl;

    // ------------------------------------------------------------------
    // Prescaler and counter
    // ------------------------------------------------------------------
    logic        running;
    logic        pwmMode;
    logic        tick;
    logic [6:0]  hit;
    logic [6:0]  hitStb;
    logic        anyReset;
    logic        anyStop;
    logic        cycleHit;
    logic [6:0]  intSel;
    logic [6:0]  resetSel;
    logic [6:0]  stopSel;

    assign running = ctrlFf[mcepwm_pkg::CTRL_RUN] & ~ctrlFf[mcepwm_pkg::CTRL_CLEAR];
    assign pwmMode = ctrlFf[mcepwm_pkg::CTRL_PWMEN];
    // A prescale value lowered below the running count still ticks at once, no 2^32 stall
    assign tick    = running && (preCountFf >= prescaleFf);

    genvar gi;
    generate
        for (gi = 0; gi < NM; gi++) begin : gMatch
            // A match fires once, on the tick that leaves the matching count
            assign hit[gi]    = (countFf == activeFf[gi]);
            assign hitStb[gi] = hit[gi] & tick;
            assign intSel[gi]   = matchCtlFf[3 * gi + mcepwm_pkg::MC_INT];
            assign resetSel[gi] = matchCtlFf[3 * gi + mcepwm_pkg::MC_RESET];
            assign stopSel[gi]  = matchCtlFf[3 * gi + mcepwm_pkg::MC_STOP];
        end
    endgenerate

    // In PWM mode match zero always resets the count
    assign anyReset = |(hitStb & resetSel) | (pwmMode & hitStb[0]);
    assign anyStop  = |(hitStb & stopSel);
    assign cycleHit = hitStb[0];

    assign nxtPreCount = (!running || tick) ? 32'h0000_0000 : preCountFf + 32'h0000_0001;
    // A stop match freezes the count on the matched value instead of stepping past it
    assign nxtCount    = ctrlFf[mcepwm_pkg::CTRL_CLEAR] ? 32'h0000_0000 :
                         anyReset ? 32'h0000_0000 :
                         anyStop ? countFf :
                         tick ? countFf + 32'h0000_0001 : countFf;

    assign nxtCtrl = (wrStb && hitAddr(paddr, mcepwm_pkg::ADDR_CTRL)) ? pwdata :
                     anyStop ? (ctrlFf & ~(32'h0000_0001 << mcepwm_pkg::CTRL_RUN)) : ctrlFf;

    // ------------------------------------------------------------------
    // Interrupt status: set wins over read-clear
    // ------------------------------------------------------------------
    logic [6:0] intEv;
    logic       rdStatus;
    assign intEv = hitStb & intSel;
    assign rdStatus  = rdStb && hitAddr(paddr, mcepwm_pkg::ADDR_STATUS);
    assign nxtStatus = (rdStatus ? 7'h00 : statusFf) | intEv;
    assign irq       = |(statusFf & intMaskFf);

    // ------------------------------------------------------------------
    // Shadow release: held until the cycle match, or taken at once as a plain timer
    // ------------------------------------------------------------------
    logic applyNow;
    assign applyNow   = pwmMode ? cycleHit : 1'b1;
    assign nxtRelease = applyNow ? 7'h00 :
                        (releaseFf | ((wrStb && hitAddr(paddr, mcepwm_pkg::ADDR_RELEASE)) ? pwdata[6:0] : 7'h00));

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ctrlFf     <= mcepwm_pkg::RST_WORD;
            prescaleFf <= mcepwm_pkg::RST_WORD;
            preCountFf <= mcepwm_pkg::RST_WORD;
            countFf    <= mcepwm_pkg::RST_WORD;
            matchCtlFf <= 21'h000000;
            pwmCtlFf   <= 15'h0000;
            releaseFf  <= 7'h00;
            statusFf   <= 7'h00;
            intMaskFf  <= 7'h00;
        end else begin
            ctrlFf     <= nxtCtrl;
            preCountFf <= nxtPreCount;
            countFf    <= nxtCount;
            releaseFf  <= nxtRelease;
            statusFf   <= nxtStatus;
            if (wrStb && hitAddr(paddr, mcepwm_pkg::ADDR_PRESCALE)) begin
                prescaleFf <= pwdata;
            end
            if (wrStb && hitAddr(paddr, mcepwm_pkg::ADDR_MATCHCTL)) begin
                matchCtlFf <= pwdata[20:0];
            end
            if (wrStb && hitAddr(paddr, mcepwm_pkg::ADDR_PWMCTL)) begin
                pwmCtlFf <= pwdata[14:0];
            end
            if (wrStb && hitAddr(paddr, mcepwm_pkg::ADDR_INTMASK)) begin
                intMaskFf <= pwdata[6:0];
            end
        end
    end

    generate
        for (gi = 0; gi < NM; gi++) begin : gShadow
            logic pend;
            // Pending release bits include one written in this same cycle
            assign pend = releaseFf[gi] |
                          (wrStb && hitAddr(paddr, mcepwm_pkg::ADDR_RELEASE) && pwdata[gi]);
            always_ff @(posedge clk_sys) begin
                if (rst) begin
                    shadowFf[gi] <= mcepwm_pkg::RST_WORD;
                    activeFf[gi] <= mcepwm_pkg::RST_WORD;
                end else begin
                    if (wrStb && inMatch && (matchIdx == 3'(gi))) begin
                        shadowFf[gi] <= pwdata;
                    end
                    if (applyNow && (pend || !pwmMode)) begin
                        activeFf[gi] <= shadowFf[gi];
                    end
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // Output channels
    // ------------------------------------------------------------------
    generate
        for (gi = 1; gi <= mcepwm_pkg::NUM_OUT; gi++) begin : gOut
            logic dbl;
            // Output 1 has no lower match to rise from, so it is single edge only
            if (gi == 1) begin : gSingle
                assign dbl = 1'b0;
            end else begin : gDual
                assign dbl = pwmCtlFf[mcepwm_pkg::PC_DBL_LSB + gi - 2];
            end
            mcepwm_output uOut (
                .clk_sys    (clk_sys),
                .rst        (rst),
                .enable     (pwmCtlFf[mcepwm_pkg::PC_EN_LSB + gi - 1] & pwmMode),
                .doubleEdge (dbl),
                .cycleHit   (cycleHit),
                .setHit     (hitStb[gi - 1]),
                .ownHit     (hitStb[gi]),
                .pwmOut     (pwmOut[gi - 1])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // Read mux, answered with no wait states
    // ------------------------------------------------------------------
    logic [31:0] rdMux;
    assign rdMux = inMatch ? shadowFf[matchIdx] :
                   hitAddr(paddr, mcepwm_pkg::ADDR_STATUS)   ? {25'h0, statusFf}   :
                   hitAddr(paddr, mcepwm_pkg::ADDR_CTRL)     ? ctrlFf              :
                   hitAddr(paddr, mcepwm_pkg::ADDR_COUNT)    ? countFf             :
                   hitAddr(paddr, mcepwm_pkg::ADDR_PRESCALE) ? prescaleFf          :
                   hitAddr(paddr, mcepwm_pkg::ADDR_PRECOUNT) ? preCountFf          :
                   hitAddr(paddr, mcepwm_pkg::ADDR_MATCHCTL) ? {11'h0, matchCtlFf} :
                   hitAddr(paddr, mcepwm_pkg::ADDR_PWMCTL)   ? {17'h0, pwmCtlFf}   :
                   hitAddr(paddr, mcepwm_pkg::ADDR_RELEASE)  ? {25'h0, releaseFf}  :
                   hitAddr(paddr, mcepwm_pkg::ADDR_INTMASK)  ? {25'h0, intMaskFf}  : 32'h0000_0000;
    assign prdata  = rdStb ? rdMux : 32'h0000_0000;
    assign pready  = 1'b1;
    assign pslverr = 1'b0;
endmodule

// ==== mcepwm_monitor.sv ====
// Port checks for the multi-channel edge PWM top.
// Assumes one clock domain and an APB master that keeps the setup/access order.
`timescale 1ns/1ps
module mcepwm_monitor (
    // Clock and reset
    input wire logic        clk_sys,
    input wire logic        rst,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    // Outputs
    input wire logic [5:0]  pwmOut,
    input wire logic        irq
);
    // ------------------------------------------------------------
    // Shadows of software writes
    // ------------------------------------------------------------
    logic [5:0] en_ff;
    logic [6:0] mask_ff;
    logic [1:0] ctl_ff;
    logic [1:0] idle_ff;
    wire        wrHit = psel && penable && pwrite;
    wire        rdHit = psel && penable && !pwrite;
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            en_ff <= 6'h00;
            mask_ff <= 7'h00;
            ctl_ff <= 2'h0;
        end else if (wrHit) begin
            if (paddr == mcepwm_pkg::ADDR_PWMCTL) en_ff <= pwdata[14:9];
            if (paddr == mcepwm_pkg::ADDR_INTMASK) mask_ff <= pwdata[6:0];
            if (paddr == mcepwm_pkg::ADDR_CTRL) ctl_ff <= {pwdata[3], pwdata[0]};
        end
    end
    // Stop by match leaves run set here, so the hold check only gets quieter
    always_ff @(posedge clk_sys) begin
        if (rst || wrHit || ctl_ff[0]) idle_ff <= 2'h0;
        else if (idle_ff != 2'h3) idle_ff <= idle_ff + 2'h1;
    end
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    ready_zero_wait_a: assert property (psel && penable |-> pready && !pslverr)
        else $error("access phase not answered at once");
    read_idle_zero_a: assert property (!rdHit |-> prdata == 32'h0000_0000)
        else $error("read data driven outside a read");
    reset_quiet_a: assert property (disable iff (1'b0) rst |=> pwmOut == 6'h00 && !irq)
        else $error("outputs active after reset");
    disabled_low_a: assert property (
        (pwmOut & ~en_ff & ~$past(en_ff)) == 6'h00) else $error("disabled output high");
    mask_quiet_a: assert property (
        mask_ff == 7'h00 && $past(mask_ff) == 7'h00 && $past(mask_ff, 2) == 7'h00 |-> !irq)
        else $error("interrupt with all sources masked");
    mask_drop_a: assert property (
        wrHit && paddr == mcepwm_pkg::ADDR_INTMASK && pwdata[6:0] == 7'h00 |-> ##2 !irq)
        else $error("interrupt stays after masking");
    stopped_hold_a: assert property (
        idle_ff == 2'h3 |-> $stable(pwmOut)) else $error("output moved while stopped");
    mode_read_a: assert property (
        rdHit && paddr == mcepwm_pkg::ADDR_CTRL |-> prdata[3] == ctl_ff[1] && (ctl_ff[0] || !prdata[0]))
        else $error("control readback wrong");
    cover property ($rose(irq));
    cover property ($fell(pwmOut[1]));
    cover property (rdHit && paddr == mcepwm_pkg::ADDR_STATUS && prdata != 32'h0);
endmodule

bind mcepwm_top mcepwm_monitor u_mon (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .pwmOut(pwmOut), .irq(irq));

// ==== mcepwm_load.sv ====
// Load model on the six PWM pins: adds up the high time of each pin in clocks.
// Assumes the pins are looked at on the bench clock; nothing drives back.
`timescale 1ns/1ps
module mcepwm_load (
    // Clock
    input  wire logic        clk_sys,
    // Pins from the block
    input  wire logic [5:0]  pwmOut,
    // High time seen so far, wraps at 16 bits
    output logic      [15:0] highCnt [6]
);
    initial for (int k = 0; k < 6; k++) highCnt[k] = 16'h0000;
    always @(posedge clk_sys) begin
        for (int k = 0; k < 6; k++) begin
            if (pwmOut[k] === 1'b1) highCnt[k] <= highCnt[k] + 16'h0001;
        end
    end
endmodule

// ==== multi_channel_edge_pwm_tb_top.sv ====
// Self-checking bench for the multi-channel edge PWM: APB master, load model, queued expectations.
// Assumes mcepwm_top, mcepwm_load and the bound monitor are compiled first.
`timescale 1ns/1ps
module multi_channel_edge_pwm_tb_top;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic        clk_sys = 1'b0;
    logic        rst     = 1'b1;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [7:0]  paddr   = 8'h00;
    logic [31:0] pwdata  = 32'h0000_0000;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    logic [5:0]  pwmOut;
    logic        irq;
    logic [15:0] highCnt [6];
    logic [15:0] d [6];
    logic [31:0] expQ [$];
    logic [31:0] obsQ [$];
    int          shown = 0;
    int          taken = 0;
    int          miscompares = 0;
    int          checks_done = 0;
    int          cycles = 0;
    int          p, per, mv [7], hi [6];

    always #20 clk_sys = ~clk_sys;

    mcepwm_top DUT (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .pwmOut(pwmOut), .irq(irq));
    mcepwm_load LOAD (.clk_sys(clk_sys), .pwmOut(pwmOut), .highCnt(highCnt));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        checks_done++;
        if (seen !== want) begin
            miscompares++;
            $display("ERROR t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask
    task automatic give_verdict;
        if (miscompares == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic note(input logic [31:0] v);
        expQ.push_back(v);
    endtask
    // Results are queued so several shown in one time step are all compared
    task automatic show(input logic [31:0] v);
        obsQ.push_back(v);
        shown++;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input int v);
        logic [31:0] t;
        apb(1'b1, a, 32'(v), t);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] want);
        logic [31:0] t;
        note(want);
        apb(1'b0, a, 32'h0, t);
        show(t);
    endtask
    // Whole periods make the high count independent of where the window starts
    task automatic measure;
        logic [15:0] s [6];
        repeat (2 * per) @(posedge clk_sys);
        #1;
        s = highCnt;
        repeat (3 * per) @(posedge clk_sys);
        #1;
        for (int k = 0; k < 6; k++) d[k] = highCnt[k] - s[k];
    endtask

    initial forever begin
        wait (taken != shown);
        check(obsQ.pop_front(), expQ.pop_front());
        taken++;
    end
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            give_verdict();
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(32'hffcd));
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        note(32'h0);
        show({26'h0, pwmOut});
        for (int a = 0; a < 40; a += 4) rd(8'(a), 32'h0);
        wr(8'h3c, 32'hffff_ffff);
        rd(8'h3c, 32'h0);
        wr(mcepwm_pkg::ADDR_COUNT, 32'h1234);
        rd(mcepwm_pkg::ADDR_COUNT, 32'h0);
        for (int r = 0; r < 2; r++) begin
            p = $urandom_range(2, 0);
            mv[0] = $urandom_range(20, 12);
            mv[1] = $urandom_range(mv[0] - 3, 1);
            mv[2] = $urandom_range(mv[0] - 1, mv[1] + 1);
            mv[3] = $urandom_range(mv[0] - 1, 2);
            mv[4] = $urandom_range(mv[3] - 1, 0);
            mv[5] = $urandom_range(mv[0] - 1, 1);
            mv[6] = $urandom_range(mv[0] - 1, 0);
            per = (mv[0] + 1) * (p + 1);
            hi = '{(mv[1] + 1) * (p + 1), (mv[2] - mv[1]) * (p + 1), (mv[3] + 1) * (p + 1),
                   (mv[0] + 1 - mv[3] + mv[4]) * (p + 1), 0, (mv[6] + 1) * (p + 1)};
            wr(mcepwm_pkg::ADDR_CTRL, 2);
            wr(mcepwm_pkg::ADDR_PRESCALE, p);
            for (int n = 0; n < 7; n++) wr(mcepwm_pkg::ADDR_MATCH0 + 8'(4 * n), mv[n]);
            wr(mcepwm_pkg::ADDR_PWMCTL, 32'h0000_5e14);
            wr(mcepwm_pkg::ADDR_CTRL, 32'h0000_0009);
            measure();
            for (int k = 0; k < 6; k++) begin
                note(32'(3 * hi[k]));
                show({16'h0, d[k]});
            end
        end
        wr(mcepwm_pkg::ADDR_MATCH0 + 8'h04, mv[0] - 2);
        for (int s = 0; s < 2; s++) begin
            if (s == 1) wr(mcepwm_pkg::ADDR_RELEASE, 32'h0000_0002);
            measure();
            note(32'(3 * (p + 1) * ((s == 1) ? mv[0] - 1 : mv[1] + 1)));
            show({16'h0, d[0]});
        end
        rd(mcepwm_pkg::ADDR_RELEASE, 32'h0);
        wr(mcepwm_pkg::ADDR_MATCHCTL, 32'h0004_9249);
        wr(mcepwm_pkg::ADDR_INTMASK, 32'h1);
        repeat (2 * per) @(posedge clk_sys);
        @(posedge pwmOut[0]);
        rd(mcepwm_pkg::ADDR_STATUS, 32'h7f);
        repeat (2) @(posedge clk_sys);
        note(32'h0);
        show({31'h0, irq});
        for (int i = 0; i < per + 4 && irq !== 1'b1; i++) @(posedge clk_sys);
        note(32'h1);
        show({31'h0, irq});
        wr(mcepwm_pkg::ADDR_INTMASK, 32'h0);
        repeat (2) @(posedge clk_sys);
        note(32'h0);
        show({31'h0, irq});
        wr(mcepwm_pkg::ADDR_CTRL, 2);
        wr(mcepwm_pkg::ADDR_MATCHCTL, 32'h0000_0140);
        wr(mcepwm_pkg::ADDR_PRESCALE, 0);
        wr(mcepwm_pkg::ADDR_MATCH0 + 8'h08, 5);
        wr(mcepwm_pkg::ADDR_CTRL, 1);
        repeat (20) @(posedge clk_sys);
        rd(mcepwm_pkg::ADDR_CTRL, 32'h0);
        rd(mcepwm_pkg::ADDR_COUNT, 32'h5);
        repeat (2) @(posedge clk_sys);
        give_verdict();
    end
endmodule
